// File: src/ctm_timer.sv
// compact 10-bit timer with period and full comparators, apb register slave
// assumes high and sub clocks arrive as enable ticks in the pclk domain;
// the external count input is asynchronous and is synchronised here
`timescale 1ns/10ps

// Operation
// - 10-bit up counter steps on each selected timer clock edge while on, unpaused
// - period value compares counter bits 9..7; full value compares all ten bits
// - period codes match at multiples of 128; code 000 means overflow at 1024
// - counter_on rise zeroes counter; fall holds it; software cannot otherwise alter it
// - counter clears itself on overflow or selected match; a selected match also raises its flag
// - pause holds the counter value; counting resumes from it when pause clears
// - clock select: sys/4, sys, high/16, high/64, sub, reserved stop, ext rise, fall
// - counter_on low stops counting and disables the module; high enables it
// - compare mode: counter_on rise returns output to its initial level
// - mode field: 00 compare, 01 undefined, 10 pwm, 11 timer/counter
// - compare mode action on full match: none, low, high, toggle
// - pwm action: inactive level, active level, waveform, undefined
// - initial level sets pre-match output, or pwm active polarity; ignored in timer mode
// - invert bit inverts the output pin; no effect in timer mode
// - swap bit exchanges period and duty roles of the two comparators in pwm
// - clear select 1 clears on full match; 0 on period match or overflow
// - pwm ignores clear select; the period comparator role governs clearing
// - counter is read-only low/high pair; full compare is read/write pair
// - low write goes to buffer copied on high write; high read latches low
// - clear select 0 raises both flags; clear select 1 raises only full flag
// - clear select 1 and full value zero wraps at 3ff without full flag
module ctm_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        high_clock_tick,
  input  wire logic        sub_clock_tick,
  input  wire logic        external_count_input,
  output logic             timer_out_a,
  output logic             timer_out_b,
  output logic             full_match_pulse,
  output logic             period_match_pulse
);
  import ctm_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] count_control_r;
  logic [7:0] mode_control_r;
  logic [9:0] counter_r;
  logic [9:0] full_compare_value_r;
  logic [7:0] byte_buffer_r;
  logic [1:0] flags_r;
  logic       out_r;
  logic       on_d_r;
  logic [1:0] ext_sync_r;
  logic       ext_prev_r;
  logic [5:0] div_sys_r;
  logic [5:0] div_h_r;
  logic [7:0] rdata_r;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire       wr_en    = psel && penable && pwrite;
  wire       rd_en    = psel && penable && !pwrite;
  wire       hit_cc   = paddr == ADDR_COUNT_CONTROL;
  wire       hit_mc   = paddr == ADDR_MODE_CONTROL;
  wire       hit_dl   = paddr == ADDR_COUNTER_LOW;
  wire       hit_dh   = paddr == ADDR_COUNTER_HIGH;
  wire       hit_al   = paddr == ADDR_COMPARE_A_LOW;
  wire       hit_ah   = paddr == ADDR_COMPARE_A_HIGH;
  wire       hit_fl   = paddr == ADDR_MATCH_FLAGS;
  wire       mapped   = hit_cc | hit_mc | hit_dl | hit_dh | hit_al | hit_ah | hit_fl;

  // ****************************************************************
  // control fields
  // ****************************************************************
  wire             count_pause          = count_control_r[PAUSE_BIT];
  wire ctm_cksel_t clock_select         = ctm_cksel_t'(count_control_r[CKSEL_HI:CKSEL_LO]);
  wire             counter_on           = count_control_r[ON_BIT];
  wire [2:0]       period_compare_value = count_control_r[PERIOD_HI:0];
  wire ctm_mode_t  mode                 = ctm_mode_t'(mode_control_r[MODE_HI:MODE_LO]);
  wire ctm_act_t   output_action        = ctm_act_t'(mode_control_r[ACT_HI:ACT_LO]);
  wire             output_initial_level = mode_control_r[INIT_BIT];
  wire             output_invert        = mode_control_r[INV_BIT];
  wire             period_duty_swap     = mode_control_r[SWAP_BIT];
  wire             clear_select         = mode_control_r[CLRSEL_BIT];

  // ****************************************************************
  // timer clock selection
  // ****************************************************************
  wire ext_now   = ext_sync_r[1];
  wire ext_rise  = ext_now && !ext_prev_r;
  wire ext_fall  = !ext_now && ext_prev_r;
  wire h_tick16  = high_clock_tick && (div_h_r[3:0] == DIV_H16[3:0]);
  wire h_tick64  = high_clock_tick && (div_h_r == DIV_H64);
  wire sys_tick4 = div_sys_r[1:0] == DIV_SYS4[1:0];
  logic tclk_sel;
  always_comb begin
    unique case (clock_select)
      CTM_CK_SYS4: tclk_sel = sys_tick4;
      CTM_CK_SYS:  tclk_sel = 1'b1;
      CTM_CK_H16:  tclk_sel = h_tick16;
      CTM_CK_H64:  tclk_sel = h_tick64;
      CTM_CK_SUB:  tclk_sel = sub_clock_tick;
      CTM_CK_RSVD: tclk_sel = 1'b0;
      CTM_CK_EXTR: tclk_sel = ext_rise;
      CTM_CK_EXTF: tclk_sel = ext_fall;
    endcase
  end
  wire on_rise = counter_on && !on_d_r;
  // a rising counter_on cycle only zeroes; counting starts on the next tick
  wire tick    = tclk_sel && counter_on && !count_pause && !on_rise;

  // ****************************************************************
  // comparators
  // ****************************************************************
  wire [9:0] cnt_inc     = counter_r + 10'h001;
  // match is taken on the value the counter steps into at this tick
  wire period_eq = (cnt_inc[9:7] == period_compare_value) && (cnt_inc[6:0] == 7'h00);
  wire overflow  = counter_r == CNT_MAX;
  wire period_zero  = period_compare_value == PERIOD_OVERFLOW_CODE;
  wire full_zero    = full_compare_value_r == CNT_ZERO;
  // code 000 matches at 1024 counts, that is at overflow
  wire period_hit   = tick && (period_zero ? overflow : period_eq);
  wire full_hit     = tick && !full_zero && (cnt_inc == full_compare_value_r);
  wire is_pwm       = mode == CTM_MODE_PWM;
  wire pwm_clear    = period_duty_swap ? (full_hit || (full_zero && tick && overflow))
                                       : period_hit;
  wire cmp_clear    = clear_select ? full_hit : period_hit;
  wire wrap         = tick && overflow;
  wire clear_evt    = is_pwm ? pwm_clear : cmp_clear;
  wire raise_period = period_hit && (is_pwm || !clear_select);
  wire raise_full   = full_hit;

  // ****************************************************************
  // counter
  // ****************************************************************
  logic [9:0] counter_nxt;
  always_comb begin
    counter_nxt = counter_r;
    if (on_rise) begin
      counter_nxt = CNT_ZERO;
    end else if (tick) begin
      counter_nxt = (clear_evt || wrap) ? CNT_ZERO : cnt_inc;
    end
  end

  // ****************************************************************
  // output generation
  // ****************************************************************
  wire [9:0] duty_lvl = period_duty_swap ? {period_compare_value, 7'h00} : full_compare_value_r;
  wire [10:0] duty_ext = (period_duty_swap && period_zero) ? 11'h400 : {1'b0, duty_lvl};
  wire [10:0] per_ext  = period_duty_swap ? (full_zero ? 11'h400 : {1'b0, full_compare_value_r})
                                          : (period_zero ? 11'h400
                                                         : {1'b0, period_compare_value, 7'h00});
  // duty at or beyond period gives 100 percent
  wire pwm_active = ({1'b0, counter_r} < duty_ext) || (duty_ext >= per_ext);
  logic pwm_level;
  always_comb begin
    unique case (output_action)
      CTM_ACT_NONE: pwm_level = !output_initial_level;
      CTM_ACT_LOW:  pwm_level = output_initial_level;
      CTM_ACT_HIGH: pwm_level = pwm_active ? output_initial_level : !output_initial_level;
      CTM_ACT_TOG:  pwm_level = !output_initial_level;
    endcase
  end
  logic out_nxt;
  always_comb begin
    out_nxt = out_r;
    if (on_rise) begin
      out_nxt = output_initial_level;
    end else if (full_hit && mode == CTM_MODE_COMPARE) begin
      unique case (output_action)
        CTM_ACT_NONE: out_nxt = out_r;
        CTM_ACT_LOW:  out_nxt = 1'b0;
        CTM_ACT_HIGH: out_nxt = 1'b1;
        CTM_ACT_TOG:  out_nxt = !out_r;
      endcase
    end
  end
  // timer/counter mode leaves the pin idle low, uninverted
  wire pin_raw = is_pwm ? pwm_level : out_r;
  wire pin_lvl = (mode == CTM_MODE_TIMER) ? 1'b0 : (pin_raw ^ output_invert);
  assign timer_out_a = pin_lvl;
  assign timer_out_b = pin_lvl;

  // ****************************************************************
  // register writes and read mux
  // ****************************************************************
  // hardware set wins over software clear (write one to clear)
  wire [1:0] flag_set = {raise_period, raise_full};
  wire [1:0] flag_clr = (wr_en && hit_fl) ? pwdata[1:0] : 2'h0;
  wire [1:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = RESET_BYTE;
    if (hit_cc) rd_byte = count_control_r;
    if (hit_mc) rd_byte = mode_control_r;
    if (hit_dl || hit_al) rd_byte = byte_buffer_r;
    if (hit_dh) rd_byte = {6'h00, counter_r[9:8]};
    if (hit_ah) rd_byte = {6'h00, full_compare_value_r[9:8]};
    if (hit_fl) rd_byte = {6'h00, flags_r};
  end
  wire [7:0] buf_nxt = (wr_en && hit_al) ? pwdata[7:0] :
                       (rd_en && hit_dh) ? counter_r[7:0] :
                       (rd_en && hit_ah) ? full_compare_value_r[7:0] : byte_buffer_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_control_r      <= RESET_BYTE;
      mode_control_r       <= RESET_BYTE;
      full_compare_value_r <= CNT_ZERO;
      byte_buffer_r        <= RESET_BYTE;
      rdata_r              <= RESET_BYTE;
    end else begin
      if (wr_en && hit_cc) count_control_r <= pwdata[7:0];
      if (wr_en && hit_mc) mode_control_r <= pwdata[7:0];
      if (wr_en && hit_ah) full_compare_value_r <= {pwdata[1:0], byte_buffer_r};
      byte_buffer_r <= buf_nxt;
      rdata_r       <= rd_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_r  <= CNT_ZERO;
      flags_r    <= 2'h0;
      out_r      <= 1'b0;
      on_d_r     <= 1'b0;
      ext_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
      div_sys_r  <= 6'h00;
      div_h_r    <= 6'h00;
    end else begin
      counter_r  <= counter_nxt;
      flags_r    <= flags_nxt;
      out_r      <= out_nxt;
      on_d_r     <= counter_on;
      ext_sync_r <= {ext_sync_r[0], external_count_input};
      ext_prev_r <= ext_sync_r[1];
      div_sys_r  <= div_sys_r + 6'h01;
      if (high_clock_tick) div_h_r <= div_h_r + 6'h01;
    end
  end

  // answer is registered: read data valid in the access cycle after setup
  assign prdata             = {24'h000000, rdata_r};
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !mapped;
  assign full_match_pulse   = raise_full;
  assign period_match_pulse = raise_period;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence on_edge_s;
    counter_on && !on_d_r;
  endsequence
  sequence zeroed_s;
    counter_r == CNT_ZERO;
  endsequence

  on_rise_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    on_edge_s |=> zeroed_s) else $error("counter not zeroed on enable");
  off_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_on |=> $stable(counter_r)) else $error("counter moved while off");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_pause && !on_rise |=> $stable(counter_r)) else $error("counter moved while paused");
  step_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !clear_evt && !wrap |=> counter_r == $past(counter_r) + 10'h001)
    else $error("counter did not step by one");
  rsvd_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    clock_select == CTM_CK_RSVD && !on_rise |=> $stable(counter_r))
    else $error("reserved clock still counts");
  init_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    on_edge_s ##0 (mode == CTM_MODE_COMPARE) |=> out_r == $past(output_initial_level))
    else $error("output not at initial level");
  no_pflag_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_select && !is_pwm |-> !period_match_pulse) else $error("period flag with full clear");
  full_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    full_hit && clear_select && !is_pwm && !on_rise |=> zeroed_s)
    else $error("full match did not clear");
  toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    full_hit && !on_rise && mode == CTM_MODE_COMPARE && output_action == CTM_ACT_TOG
    |=> out_r != $past(out_r)) else $error("toggle missed");
  invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == CTM_MODE_COMPARE |-> timer_out_a == (out_r ^ output_invert))
    else $error("pin polarity wrong");
endmodule

// File: src/ctm_pkg.sv
// package for the compact timer: register map, field positions, encodings
// assumes an apb slave with 32-bit data and one register per aligned word
package ctm_pkg;
  localparam logic [11:0] ADDR_COUNT_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_MODE_CONTROL    = 12'h004;
  localparam logic [11:0] ADDR_COUNTER_LOW     = 12'h008;
  localparam logic [11:0] ADDR_COUNTER_HIGH    = 12'h00c;
  localparam logic [11:0] ADDR_COMPARE_A_LOW   = 12'h010;
  localparam logic [11:0] ADDR_COMPARE_A_HIGH  = 12'h014;
  localparam logic [11:0] ADDR_MATCH_FLAGS     = 12'h018;
  localparam logic [7:0]  RESET_BYTE           = 8'h00;
  localparam logic [9:0]  CNT_ZERO             = 10'h000;
  localparam logic [9:0]  CNT_MAX              = 10'h3ff;
  localparam logic [2:0]  PERIOD_OVERFLOW_CODE = 3'h0;
  // count_control fields
  localparam int PAUSE_BIT   = 7;
  localparam int CKSEL_HI    = 6;
  localparam int CKSEL_LO    = 4;
  localparam int ON_BIT      = 3;
  localparam int PERIOD_HI   = 2;
  // mode_control fields
  localparam int MODE_HI     = 7;
  localparam int MODE_LO     = 6;
  localparam int ACT_HI      = 5;
  localparam int ACT_LO      = 4;
  localparam int INIT_BIT    = 3;
  localparam int INV_BIT     = 2;
  localparam int SWAP_BIT    = 1;
  localparam int CLRSEL_BIT  = 0;
  // match flag fields
  localparam int FULL_FLAG_BIT   = 0;
  localparam int PERIOD_FLAG_BIT = 1;
  // divider ratios
  localparam logic [5:0] DIV_SYS4  = 6'h03;
  localparam logic [5:0] DIV_H16   = 6'h0f;
  localparam logic [5:0] DIV_H64   = 6'h3f;
  typedef enum logic [1:0] {
    CTM_MODE_COMPARE = 2'h0,
    CTM_MODE_UNDEF   = 2'h1,
    CTM_MODE_PWM     = 2'h2,
    CTM_MODE_TIMER   = 2'h3
  } ctm_mode_t;
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS  = 3'h1,
    CTM_CK_H16  = 3'h2,
    CTM_CK_H64  = 3'h3,
    CTM_CK_SUB  = 3'h4,
    CTM_CK_RSVD = 3'h5,
    CTM_CK_EXTR = 3'h6,
    CTM_CK_EXTF = 3'h7
  } ctm_cksel_t;
  typedef enum logic [1:0] {
    CTM_ACT_NONE = 2'h0,
    CTM_ACT_LOW  = 2'h1,
    CTM_ACT_HIGH = 2'h2,
    CTM_ACT_TOG  = 2'h3
  } ctm_act_t;
endpackage

// File: dv/compact_timer_module_test.sv
// bench for the compact timer: apb access, clock sources, compare and pwm output
// assumes the zero-wait apb slave and register map of ctm_pkg, one 50 MHz pclk
`timescale 1ns/10ps
module compact_timer_module_test;
  import ctm_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic        hck      = 1'b0;
  logic        sck      = 1'b0;
  logic        ext      = 1'b0;
  logic [1:0]  sph      = 2'h0;
  logic [2:0]  eph      = 3'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        oa;
  logic        ob;
  logic        fpl;
  logic        ppl;
  int          failures = 0;
  int          compares = 0;
  int          cyc;

  ctm_timer i_ctm_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_clock_tick(hck), .sub_clock_tick(sck),
    .external_count_input(ext), .timer_out_a(oa), .timer_out_b(ob),
    .full_match_pulse(fpl), .period_match_pulse(ppl));

  always #10 pclk = ~pclk;

  // high tick every 2nd cycle, sub tick every 3rd, external input period 8 cycles
  always @(posedge pclk) begin
    hck <= ~hck;
    sph <= (sph == 2'h2) ? 2'h0 : sph + 2'h1;
    sck <= (sph == 2'h0);
    eph <= eph + 3'h1;
    ext <= eph[2];
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // high byte first so the low byte is latched coherently
  task automatic rd_cnt(output logic [9:0] v);
    apb(1'b0, ADDR_COUNTER_HIGH, 32'h0);
    v[9:8] = rd[1:0];
    apb(1'b0, ADDR_COUNTER_LOW, 32'h0);
    v[7:0] = rd[7:0];
  endtask

  task automatic set_full(input logic [9:0] v);
    apb(1'b1, ADDR_COMPARE_A_LOW, {24'h0, v[7:0]});
    apb(1'b1, ADDR_COMPARE_A_HIGH, {30'h0, v[9:8]});
  endtask

  // returns cycles up to the next pulse, 0 when none came within the bound
  task automatic wait_pulse(input logic per, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while ((per ? ppl : fpl) !== 1'b1 && c < 3000);
    if (c >= 3000) c = 0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, ADDR_COUNT_CONTROL, 32'h0);
    check("count_control reset", rd, 32'h0);
    apb(1'b0, ADDR_MODE_CONTROL, 32'h0);
    check("mode_control reset", rd, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
  endtask

  task automatic t_buffer();
    apb(1'b1, ADDR_COMPARE_A_LOW, 32'h55);
    apb(1'b0, ADDR_COMPARE_A_HIGH, 32'h0);
    apb(1'b0, ADDR_COMPARE_A_LOW, 32'h0);
    check("low before high write", rd, 32'h0);
    apb(1'b1, ADDR_COMPARE_A_LOW, 32'h55);
    apb(1'b1, ADDR_COMPARE_A_HIGH, 32'h2);
    apb(1'b0, ADDR_COMPARE_A_HIGH, 32'h0);
    check("compare high", rd, 32'h2);
    apb(1'b0, ADDR_COMPARE_A_LOW, 32'h0);
    check("compare low", rd, 32'h55);
  endtask

  task automatic t_clock();
    int spc[8] = '{20, 5, 160, 640, 15, 0, 40, 40};
    set_full(10'h005);
    apb(1'b1, ADDR_MODE_CONTROL, 32'h01);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h08 | (k << 4));
      wait_pulse(1'b0, cyc);
      wait_pulse(1'b0, cyc);
      check("full match spacing", cyc, spc[k]);
    end
  endtask

  task automatic t_period();
    set_full(10'h000);
    apb(1'b1, ADDR_MODE_CONTROL, 32'h00);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h18 | k);
      wait_pulse(1'b1, cyc);
      wait_pulse(1'b1, cyc);
      check("period spacing", cyc, (k == 0) ? 1024 : k * 128);
    end
    apb(1'b0, ADDR_MATCH_FLAGS, 32'h0);
    check("period flag", rd[PERIOD_FLAG_BIT], 32'h1);
  endtask

  task automatic t_pause();
    logic [9:0] a;
    logic [9:0] b;
    wait_pulse(1'b1, cyc);
    apb(1'b1, ADDR_COUNT_CONTROL, 32'h98);
    rd_cnt(a);
    rd_cnt(b);
    check("paused count", b, a);
    apb(1'b1, ADDR_COUNTER_LOW, 32'hff);
    apb(1'b1, ADDR_COUNTER_HIGH, 32'h3);
    rd_cnt(b);
    check("count after write", b, a);
    apb(1'b1, ADDR_COUNT_CONTROL, 32'h18);
    rd_cnt(b);
    check("resumed", {31'h0, (b > a) && (b - a < 10'd40)}, 32'h1);
    repeat (100) @(posedge pclk);
    apb(1'b1, ADDR_COUNT_CONTROL, 32'h10);
    rd_cnt(a);
    rd_cnt(b);
    check("held when off", b, a);
    apb(1'b1, ADDR_COUNT_CONTROL, 32'h18);
    rd_cnt(b);
    check("cleared on", {31'h0, b < 10'd8}, 32'h1);
  endtask

  task automatic t_compare();
    logic ini;
    logic exp;
    set_full(10'h005);
    for (int a = 0; a < 4; a++) begin
      ini = (a != 2);
      exp = (a == 0) ? ini : (a == 1) ? 1'b0 : (a == 2) ? 1'b1 : ~ini;
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h10);
      apb(1'b1, ADDR_MODE_CONTROL, (a << 4) | (ini << 3) | 1);
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h18);
      // the output register takes the initial level one edge after the enabling write
      @(posedge pclk);
      #1;
      check("initial level", {ob, oa}, {2{ini}});
      wait_pulse(1'b0, cyc);
      #1;
      check("match action", {ob, oa}, {2{exp}});
    end
  endtask

  // pwm with period code 001: waveform, polarity, swap, full duty, forced levels, timer mode
  task automatic t_pwm();
    int mc[9]  = '{'ha8, 'ha1, 'haa, 'hac, 'ha8, 'h98, 'h9c, 'h88, 'hc8};
    int fv[9]  = '{32, 32, 200, 32, 200, 32, 32, 32, 32};
    int win[9] = '{128, 128, 200, 128, 128, 128, 128, 128, 128};
    int hx[9]  = '{32, 96, 128, 96, 128, 128, 0, 0, 0};
    int hi;
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h11);
      apb(1'b1, ADDR_MODE_CONTROL, mc[k]);
      set_full(fv[k]);
      apb(1'b1, ADDR_COUNT_CONTROL, 32'h19);
      repeat (300) @(posedge pclk);
      hi = 0;
      repeat (win[k]) begin
        @(posedge pclk);
        hi += (oa === 1'b1) && (ob === 1'b1);
      end
      check("pwm high cycles", hi, hx[k]);
    end
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_buffer();
    t_clock();
    t_period();
    t_pause();
    t_compare();
    t_pwm();
    tally_and_finish();
  end

  // the whole run needs about 22000 cycles
  initial begin
    #(20 * 80000);
    failures++;
    tally_and_finish();
  end
endmodule
